/* File: common/clock_routing_pkg.sv */
// Constants, register layouts and enumerations shared by both ends of the clock and trigger link.
`default_nettype none
package clock_routing_pkg;

    // Rates of the system clock and of every derived signal.
    localparam int CLOCK_HZ = 100_000_000;
    localparam int TB20_HZ = 20_000_000;
    localparam int TB100K_HZ = 100_000;
    localparam int REFOUT_HZ = 10_000_000;
    localparam int SYNC_HZ = 10_000_000;
    localparam int REF5_HZ = 5_000_000;
    localparam int REF10_HZ = 10_000_000;
    localparam int REF20_HZ = 20_000_000;
    localparam int REF100_HZ = 100_000_000;

    // Cycle counts derived from the rates above.
    localparam int TB20_DIV = CLOCK_HZ / TB20_HZ;
    localparam int TB100K_DIV = CLOCK_HZ / TB100K_HZ;
    localparam int REFOUT_DIV = CLOCK_HZ / REFOUT_HZ;
    localparam int SYNC_DIV = CLOCK_HZ / SYNC_HZ;
    localparam logic [4:0] PER_5M = 5'(CLOCK_HZ / REF5_HZ);
    localparam logic [4:0] PER_10M = 5'(CLOCK_HZ / REF10_HZ);
    localparam logic [4:0] PER_20M = 5'(CLOCK_HZ / REF20_HZ);
    localparam logic [4:0] PER_100M = 5'(CLOCK_HZ / REF100_HZ);
    localparam logic [4:0] PER_ONE = 5'h01;
    localparam logic [3:0] LOCK_TICKS = 4'h8;

    // Counter widths and terminal values.
    localparam logic [2:0] TB20_LAST = 3'(TB20_DIV - 1);
    localparam logic [9:0] TB100K_LAST = 10'(TB100K_DIV - 1);
    localparam logic [3:0] REFOUT_LAST = 4'(REFOUT_DIV - 1);
    localparam logic [3:0] SYNC_LAST = 4'(SYNC_DIV - 1);
    localparam int TRIG_LINES = 8;

    // Register byte addresses on the APB port.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    typedef enum logic [2:0] {REF_INTERNAL, REF_TRIG, REF_PFI, REF_CLK100, REF_STAR,
                              REF_DSTAR_A} ref_src_e;
    typedef enum logic [1:0] {TRIG_BUS, TRIG_PFI, TRIG_STAR, TRIG_DSTAR_B} trig_src_e;
    typedef enum logic [1:0] {TB_100M, TB_20M, TB_100K, TB_OFF} tb_sel_e;
    typedef enum logic {ROLE_SLAVE, ROLE_MASTER} sync_role_setting_e;

    // Control register layout, most significant field first.
    typedef struct packed {
        logic [6:0] spare;
        logic dstar_c_clock;
        logic dstar_c_en;
        logic [2:0] trig_out_line;
        logic trig_export_en;
        logic [2:0] trig_line;
        trig_src_e trig_src;
        tb_sel_e tb_sel;
        sync_role_setting_e sync_role_setting;
        logic skew_en;
        logic [2:0] refout_line;
        logic refout_en;
        logic [2:0] ref_line;
        ref_src_e ref_src;
    } ctrl_s;

    // Status register layout.
    typedef struct packed {
        logic [27:0] spare;
        logic trig_pending;
        logic dstar_usable;
        logic ext_selected;
        logic locked;
    } status_s;

    localparam ctrl_s CTRL_RESET = '0;
    localparam logic [31:0] CMD_START = 32'h0000_0001;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : clock_routing_pkg
`default_nettype wire

/* File: common/clock_link_if.sv */
// Backplane clock and trigger link between a module and the chassis side.
`timescale 1ns/10ps
`default_nettype none
interface clock_link_if;
    logic [7:0] trig_dev_o;
    logic [7:0] trig_dev_oe;
    logic [7:0] trig_peer_o;
    logic [7:0] trig_peer_oe;
    logic [7:0] trig;
    logic [1:0] programmable_function_input;
    logic clk100;
    logic sync100;
    logic star;
    logic dstar_a;
    logic dstar_b;
    logic dstar_c;
    logic timing_present;

    // Each bused line reads high while any enabled driver pulls it high.
    assign trig = (trig_dev_o & trig_dev_oe) | (trig_peer_o & trig_peer_oe);

    modport device (
        output trig_dev_o, trig_dev_oe, dstar_c,
        input trig, programmable_function_input, clk100, sync100, star, dstar_a, dstar_b, timing_present
    );
    modport backplane (
        output trig_peer_o, trig_peer_oe, programmable_function_input, clk100, sync100, star, dstar_a, dstar_b,
        timing_present,
        input trig, dstar_c
    );
endinterface : clock_link_if
`default_nettype wire

/* File: rtl/ref_clock_routing.sv */
// Module end: reference selection, lock watch, timebases, reference output and trigger routing.
// Notes on behaviour
// R1: Reference is internal oscillator or one external line.
// R2: Reference input: 5, 10, 20, 100 MHz.
// R3: External reference is locked and yields 100 MHz.
// R4: Timebases: 100 MHz, 20 MHz, 100 kHz.
// R5: Divide onboard oscillator down to 10 MHz output.
// R6: Reference output may drive any bused trigger line.
// R7: Backplane 10 MHz clock is never a reference.
// R8: Backplane sends 10 MHz sync at 10% duty.
// R9: Bused trigger lines are both received and driven.
// R10: Star line is received only, never driven.
// R11: Differential A clock, B trigger, C output.
// R12: Differential lines usable only with timing module.
// R13: Skew correction fires triggers on later sync edge.
// R14: Master or slave synchronisation role is configurable.
// R15: Master drives reference onto line; all select it.
// R16: Timing controller drives star line with clock.
// R17: Keep external reference present while in use.
// R18: Common start trigger aligns identically clocked modules.
// R19: Report lock; hold timebases idle until locked.
`timescale 1ns/10ps
`default_nettype none
module ref_clock_routing (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_timebase,
    output logic o_trigger,
    output logic o_locked,
    clock_link_if.device link
);

    typedef struct packed {
        clock_routing_pkg::ctrl_s ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [4:0] interval;
        logic [4:0] last_period;
        logic [3:0] good;
        logic locked;
        logic [3:0] refdiv;
        logic [2:0] tb20_cnt;
        logic [9:0] tb100k_cnt;
        logic timebase;
        logic trig_prev;
        logic sync_prev;
        logic pending;
        logic trigger;
        logic [7:0] bus_o;
        logic [7:0] bus_oe;
        logic dstar_c;
    } state_s;

    state_s cur;
    state_s next;

    // Accepts only the reference periods that the lock loop can follow.
    function automatic logic period_ok(input logic [4:0] p);
        period_ok = (p == clock_routing_pkg::PER_5M) || (p == clock_routing_pkg::PER_10M) ||
                    (p == clock_routing_pkg::PER_20M) || (p == clock_routing_pkg::PER_100M);
    endfunction : period_ok

    logic ref_tick;
    logic ext_sel;
    logic dstar_ok;
    logic trig_level;
    logic access;
    logic wr;
    logic rd;
    logic sync_rise;
    logic trig_edge;
    logic start_pulse;
    logic refout_level;
    clock_routing_pkg::status_s status;

    // Source selection for reference and trigger, and APB decode.
    always_comb
    begin
        dstar_ok = link.timing_present; // R12
        ref_tick = 1'b0;
        ext_sel = 1'b1;
        case (cur.ctrl.ref_src) // R1 R7
            clock_routing_pkg::REF_TRIG: ref_tick = link.trig[cur.ctrl.ref_line]; // R15
            clock_routing_pkg::REF_PFI: ref_tick = link.programmable_function_input[cur.ctrl.ref_line[0]];
            clock_routing_pkg::REF_CLK100: ref_tick = link.clk100;
            clock_routing_pkg::REF_STAR: ref_tick = link.star; // R10
            clock_routing_pkg::REF_DSTAR_A: ref_tick = link.dstar_a & dstar_ok; // R11 R12
            default: ext_sel = 1'b0;
        endcase
        case (cur.ctrl.trig_src) // R9
            clock_routing_pkg::TRIG_BUS: trig_level = link.trig[cur.ctrl.trig_line];
            clock_routing_pkg::TRIG_PFI: trig_level = link.programmable_function_input[cur.ctrl.trig_line[0]];
            clock_routing_pkg::TRIG_STAR: trig_level = link.star; // R10
            clock_routing_pkg::TRIG_DSTAR_B: trig_level = link.dstar_b & dstar_ok; // R11 R12
            default: trig_level = 1'b0;
        endcase
        access = i_psel && i_penable && cur.pready;
        wr = access && i_pwrite;
        rd = access && !i_pwrite;
        sync_rise = link.sync100 && !cur.sync_prev;
        trig_edge = trig_level && !cur.trig_prev;
        start_pulse = wr && (i_paddr == clock_routing_pkg::ADDR_CMD) &&
                      i_pwdata[0] && (cur.ctrl.sync_role_setting ==
                      clock_routing_pkg::ROLE_MASTER); // R14 R18
        refout_level = (cur.refdiv == 4'h0); // R5
        status = '0;
        status.locked = cur.locked;
        status.ext_selected = ext_sel;
        status.dstar_usable = dstar_ok;
        status.trig_pending = cur.pending;
    end

    // Next state of registers, lock watch, dividers and trigger path.
    always_comb
    begin
        next = cur;

        // One wait state: ready rises in the second access cycle.
        next.pready = i_psel && i_penable && !cur.pready;
        next.pslverr = 1'b0;
        if (i_psel && i_penable && !cur.pready)
        begin
            next.pslverr = !((i_paddr == clock_routing_pkg::ADDR_CTRL) ||
                             (i_paddr == clock_routing_pkg::ADDR_CMD) ||
                             (i_paddr == clock_routing_pkg::ADDR_STATUS));
            case (i_paddr)
                clock_routing_pkg::ADDR_CTRL: next.prdata = 32'(cur.ctrl);
                clock_routing_pkg::ADDR_STATUS: next.prdata = 32'(status);
                default: next.prdata = clock_routing_pkg::READ_ZERO;
            endcase
        end
        if (wr && (i_paddr == clock_routing_pkg::ADDR_CTRL))
        begin
            next.ctrl = clock_routing_pkg::ctrl_s'(i_pwdata);
            next.ctrl.spare = '0;
        end

        // Lock watch on the selected reference, one tick marks each period.
        if (ref_tick)
        begin
            next.interval = clock_routing_pkg::PER_ONE;
            next.last_period = cur.interval;
            if (period_ok(cur.interval) && (cur.interval == cur.last_period)) // R2 R3
                next.good = (cur.good == clock_routing_pkg::LOCK_TICKS) ? cur.good
                            : cur.good + 4'h1;
            else
                next.good = 4'h0;
        end
        else if (cur.interval > clock_routing_pkg::PER_5M)
        begin
            next.good = 4'h0; // R17
        end
        else
        begin
            next.interval = cur.interval + 5'h01;
        end
        if (next.ctrl.ref_src != cur.ctrl.ref_src)
            next.good = 4'h0;
        next.locked = !ext_sel || (next.good == clock_routing_pkg::LOCK_TICKS); // R3 R19

        // Timebases run only while the reference is locked.
        next.tb20_cnt = (!cur.locked || cur.tb20_cnt == clock_routing_pkg::TB20_LAST) ? 3'h0
                        : cur.tb20_cnt + 3'h1; // R4 R19
        next.tb100k_cnt = (!cur.locked || cur.tb100k_cnt == clock_routing_pkg::TB100K_LAST)
                          ? 10'h000 : cur.tb100k_cnt + 10'h001;
        case (cur.ctrl.tb_sel) // R4
            clock_routing_pkg::TB_100M: next.timebase = cur.locked;
            clock_routing_pkg::TB_20M: next.timebase = cur.locked && (cur.tb20_cnt == 3'h0);
            clock_routing_pkg::TB_100K: next.timebase = cur.locked &&
                                                        (cur.tb100k_cnt == 10'h000);
            default: next.timebase = 1'b0;
        endcase

        // Reference output divider free-runs on the onboard oscillator.
        next.refdiv = (cur.refdiv == clock_routing_pkg::REFOUT_LAST) ? 4'h0
                      : cur.refdiv + 4'h1; // R5

        // Trigger path with optional alignment to the sync clock.
        next.trig_prev = trig_level;
        next.sync_prev = link.sync100;
        if (cur.ctrl.skew_en)
        begin
            next.trigger = cur.pending && sync_rise; // R13
            next.pending = trig_edge || (cur.pending && !sync_rise); // R13
        end
        else
        begin
            next.trigger = trig_edge;
            next.pending = 1'b0;
        end

        // Bused line drivers: reference output wins over trigger export.
        for (int i = 0; i < clock_routing_pkg::TRIG_LINES; i++)
        begin
            next.bus_oe[i] = 1'b0;
            next.bus_o[i] = 1'b0;
            if (cur.ctrl.refout_en && (cur.ctrl.refout_line == 3'(i)))
            begin
                next.bus_oe[i] = 1'b1; // R6 R15
                next.bus_o[i] = refout_level;
            end
            else if (cur.ctrl.trig_export_en && (cur.ctrl.trig_out_line == 3'(i)))
            begin
                next.bus_oe[i] = 1'b1; // R9 R18
                next.bus_o[i] = start_pulse;
            end
        end
        next.dstar_c = dstar_ok && cur.ctrl.dstar_c_en &&
                       (cur.ctrl.dstar_c_clock ? refout_level : start_pulse); // R11 R12
    end

    // State register.
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cur <= '0;
            cur.ctrl <= clock_routing_pkg::CTRL_RESET;
            cur.locked <= 1'b1;
        end
        else
        begin
            cur <= next;
        end
    end

    assign o_prdata = cur.prdata;
    assign o_pready = cur.pready;
    assign o_pslverr = cur.pslverr;
    assign o_timebase = cur.timebase;
    assign o_trigger = cur.trigger;
    assign o_locked = cur.locked; // R19
    assign link.trig_dev_o = cur.bus_o;
    assign link.trig_dev_oe = cur.bus_oe;
    assign link.dstar_c = cur.dstar_c;

endmodule : ref_clock_routing
`default_nettype wire

/* File: rtl/chassis_timing_end.sv */
// Chassis end: backplane clocks, sync clock, star lines, peer trigger drivers.
`timescale 1ns/10ps
`default_nettype none
module chassis_timing_end (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_present,
    input wire logic i_star_clock,
    input wire logic i_star_trig,
    input wire logic i_dstar_b_trig,
    input wire logic [1:0] i_pfi,
    input wire logic [7:0] i_peer_oe,
    input wire logic [7:0] i_peer_o,
    output logic [7:0] o_trig_bus,
    output logic o_dstar_c,
    clock_link_if.backplane link
);

    typedef struct packed {
        logic [3:0] sync_cnt;
        logic clk100;
        logic sync100;
        logic star;
        logic dstar_a;
        logic dstar_b;
        logic present;
        logic [1:0] programmable_function_input;
        logic [7:0] peer_o;
        logic [7:0] peer_oe;
        logic [7:0] trig_bus;
        logic dstar_c;
    } state_s;

    state_s cur;
    state_s next;
    logic tick10;

    // Clock sources and line drivers of the chassis and timing slot.
    always_comb
    begin
        next = cur;
        tick10 = (cur.sync_cnt == 4'h0);
        next.sync_cnt = (cur.sync_cnt == clock_routing_pkg::SYNC_LAST) ? 4'h0
                        : cur.sync_cnt + 4'h1;
        next.clk100 = 1'b1; // R2
        next.sync100 = tick10; // R8
        next.present = i_present;
        next.star = i_present && (i_star_clock ? tick10 : i_star_trig); // R16 R17
        next.dstar_a = i_present && tick10;
        next.dstar_b = i_present && i_dstar_b_trig;
        next.programmable_function_input = i_pfi;
        next.peer_o = i_peer_o; // R15 R18
        next.peer_oe = i_peer_oe;
        next.trig_bus = link.trig;
        next.dstar_c = i_present && link.dstar_c;
    end

    // State register.
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            cur <= '0;
        else
            cur <= next;
    end

    assign link.clk100 = cur.clk100;
    assign link.sync100 = cur.sync100;
    assign link.star = cur.star;
    assign link.dstar_a = cur.dstar_a;
    assign link.dstar_b = cur.dstar_b;
    assign link.timing_present = cur.present;
    assign link.programmable_function_input = cur.programmable_function_input;
    assign link.trig_peer_o = cur.peer_o;
    assign link.trig_peer_oe = cur.peer_oe;
    assign o_trig_bus = cur.trig_bus;
    assign o_dstar_c = cur.dstar_c;

endmodule : chassis_timing_end
`default_nettype wire

/* File: verification/reference_clock_and_trigger_routing_asserts.sv */
// Checks on the clock link and on the module end's bus and timing outputs.
`timescale 1ns/10ps
`default_nettype none
module reference_clock_and_trigger_routing_asserts (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic clk100,
    input wire logic sync100,
    input wire logic timing_present,
    input wire logic dstar_a,
    input wire logic dstar_c,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_locked,
    input wire logic o_timebase,
    input wire logic o_trigger
);
    // All checks share the one clock and the asynchronous reset.
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    // Nine quiet cycles, then the next sync tick.
    sequence sync_gap;
        !sync100 [*8] ##1 !sync100 ##1 sync100;
    endsequence

    // One wait state, a single answer cycle, then quiet.
    sequence one_wait;
        !o_pready ##1 o_pready ##1 !o_pready;
    endsequence

    a_sync_period: assert property (sync100 |=> sync_gap)
        else $error("sync tick spacing wrong");
    a_clk100_steady: assert property (clk100 |=> clk100)
        else $error("backplane clock dropped");
    a_dstar_c_gated: assert property
        (!timing_present && !$past(timing_present) |-> !dstar_c)
        else $error("dstar_c driven without timing module");
    a_dstar_a_present: assert property (dstar_a |-> timing_present)
        else $error("dstar_a ticks without timing module");
    a_timebase_held: assert property
        (!o_locked && !$past(o_locked) |-> !o_timebase)
        else $error("timebase runs while unlocked");
    a_apb_wait: assert property (i_psel && $rose(i_penable) |-> one_wait)
        else $error("bus answer not after one wait state");
    a_apb_answer: assert property
        (o_pready |-> i_psel && i_penable && $past(i_penable))
        else $error("bus answer without access phase");
    a_trigger_pulse: assert property (o_trigger |=> !o_trigger)
        else $error("trigger longer than one cycle");
endmodule : reference_clock_and_trigger_routing_asserts
`default_nettype wire

/* File: verification/reference_clock_and_trigger_routing_tb.sv */
// Self-checking bench joining the module end and the chassis end over the link.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
            n_errors++; \
        end \
    end
module reference_clock_and_trigger_routing_tb;
    logic i_clock, i_nrst, psel, penable, pwrite, pready, pslverr, timebase, trigger;
    logic locked, present, star_clock, src_level, pfi_tick_en, dstar_c_out, prev_sync;
    logic lat_sync, rerr;
    logic [7:0] paddr, peer_oe, tick_cnt, pfi_per, trig_bus;
    logic [31:0] pwdata, prdata, rdata;
    logic [1:0] programmable_function_input;
    int n_errors = 0, n_compared = 0, cycles = 0, n_bus, n_oth, n_dc, n_tb, lat, cnt;
    clock_routing_pkg::ctrl_s cfg;
    clock_link_if link ();

    // The two ends face each other; the checker watches the link between them.
    ref_clock_routing ref_clock_routing_inst (.i_clock(i_clock), .i_nrst(i_nrst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_timebase(timebase), .o_trigger(trigger), .o_locked(locked), .link(link));
    chassis_timing_end chassis_timing_end_inst (.i_clock(i_clock), .i_nrst(i_nrst),
        .i_present(present), .i_star_clock(star_clock), .i_star_trig(src_level),
        .i_dstar_b_trig(src_level), .i_pfi(programmable_function_input), .i_peer_oe(peer_oe),
        .i_peer_o({8{src_level}}), .o_trig_bus(trig_bus), .o_dstar_c(dstar_c_out),
        .link(link));
    reference_clock_and_trigger_routing_asserts asserts_inst (.i_clock(i_clock),
        .i_nrst(i_nrst), .clk100(link.clk100), .sync100(link.sync100),
        .timing_present(link.timing_present), .dstar_a(link.dstar_a),
        .dstar_c(link.dstar_c), .i_psel(psel), .i_penable(penable), .o_pready(pready),
        .o_locked(locked), .o_timebase(timebase), .o_trigger(trigger));

    // Programmable inputs tick once per period, or follow the trigger level.
    assign programmable_function_input = pfi_tick_en ? {2{tick_cnt == 8'h00}} : {2{src_level}};

    // Free-running clock.
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Tick divider, sync history and the hang guard.
    always @(posedge i_clock)
    begin
        tick_cnt <= (tick_cnt + 8'h01 >= pfi_per) ? 8'h00 : tick_cnt + 8'h01;
        prev_sync <= link.sync100;
        cycles++;
        if (cycles > 20000)
        begin
            n_errors++;
            test_done();
        end
    end

    // Expected timebase high cycles over a window of n cycles.
    function automatic int tb_expect(input int sel, input int n);
        return (sel == 0) ? n : (sel == 1) ? n / clock_routing_pkg::TB20_DIV :
            (sel == 2) ? n / clock_routing_pkg::TB100K_DIV : 0;
    endfunction : tb_expect

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // One bus transfer; request held until the answer edge, then one idle cycle.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1)
        begin
            @(posedge i_clock);
        end
        `CHECK("bus answer", 1'b1, pready)
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clock);
    endtask : apb

    // Writes the control word and lets it settle.
    task automatic set_ctrl(input int settle);
        apb(1'b1, clock_routing_pkg::ADDR_CTRL, cfg);
        repeat (settle) @(posedge i_clock);
    endtask : set_ctrl

    // Counts activity over n cycles, optionally raising the trigger sources briefly.
    task automatic watch(input int n, input logic [2:0] k, input logic pulse);
        n_bus = 0;
        n_oth = 0;
        n_dc = 0;
        n_tb = 0;
        cnt = 0;
        lat = 0;
        src_level <= pulse;
        for (int i = 1; i <= n; i++)
        begin
            @(posedge i_clock);
            if (i == 3)
                src_level <= 1'b0;
            n_bus += int'(trig_bus[k] === 1'b1);
            n_oth += int'((trig_bus & ~(8'h01 << k)) != 8'h00);
            n_dc += int'(dstar_c_out === 1'b1);
            n_tb += int'(timebase === 1'b1);
            if (trigger === 1'b1 && cnt++ == 0)
            begin
                lat = i;
                lat_sync = prev_sync;
            end
        end
    endtask : watch

    // Main sequence: reset, then one test after another.
    initial
    begin
        {i_nrst, psel, penable, pwrite, src_level} = 5'h00;
        {paddr, peer_oe, tick_cnt, pwdata} = 56'h0;
        {present, star_clock, pfi_tick_en} = 3'h7;
        pfi_per = 8'h0a;
        void'($urandom(10553));
        repeat (8) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        apb(1'b0, clock_routing_pkg::ADDR_CTRL, 32'h0);
        `CHECK("ctrl reset", 32'(clock_routing_pkg::CTRL_RESET), rdata)
        apb(1'b0, clock_routing_pkg::ADDR_STATUS, 32'h0);
        `CHECK("status reset", 32'h0000_0005, rdata)
        `CHECK("mapped error", 1'b0, rerr)
        apb(1'b0, 8'h0c, 32'h0);
        `CHECK("unmapped error", 1'b1, rerr)
        `CHECK("unmapped data", 32'h0, rdata)
        cfg = clock_routing_pkg::ctrl_s'($urandom);
        set_ctrl(0);
        apb(1'b1, 8'h10, 32'hffff_ffff);
        apb(1'b0, clock_routing_pkg::ADDR_CTRL, 32'h0);
        `CHECK("ctrl readback", cfg & 32'h01ff_ffff, rdata)
        apb(1'b0, clock_routing_pkg::ADDR_CMD, 32'h0);
        `CHECK("cmd read", 32'h0, rdata)
        $display("register test done");
        for (int s = 0; s < 4; s++)
        begin
            cfg = '0;
            cfg.tb_sel = clock_routing_pkg::tb_sel_e'(s);
            set_ctrl(10);
            watch(1000, 3'h0, 1'b0);
            `CHECK("timebase ticks", tb_expect(s, 1000), n_tb)
        end
        $display("timebase test done");
        for (int s = 1; s < 7; s++)
        begin
            cfg = '0;
            cfg.ref_src = clock_routing_pkg::ref_src_e'(s);
            cfg.ref_line = 3'($urandom);
            cfg.refout_en = 1'b1;
            cfg.refout_line = cfg.ref_line;
            set_ctrl(3);
            `CHECK("lock after switch", s == 6, locked)
            repeat (200) @(posedge i_clock);
            apb(1'b0, clock_routing_pkg::ADDR_STATUS, 32'h0);
            `CHECK("lock on source", 1'b1, locked)
            `CHECK("external flag", s != 6, rdata[1])
        end
        pfi_per <= 8'h07;
        cfg = '0;
        cfg.ref_src = clock_routing_pkg::REF_PFI;
        set_ctrl(300);
        watch(100, 3'h0, 1'b0);
        `CHECK("lock at bad rate", 1'b0, locked)
        `CHECK("timebase idle", 0, n_tb)
        pfi_per <= 8'h14;
        repeat (400) @(posedge i_clock);
        `CHECK("lock at 5 MHz", 1'b1, locked)
        pfi_tick_en <= 1'b0;
        $display("lock test done");
        cfg = '0;
        cfg.refout_en = 1'b1;
        cfg.refout_line = 3'($urandom);
        cfg.dstar_c_en = 1'b1;
        cfg.dstar_c_clock = 1'b1;
        set_ctrl(5);
        watch(100, cfg.refout_line, 1'b0);
        `CHECK("refout ticks", 100 / clock_routing_pkg::REFOUT_DIV, n_bus)
        `CHECK("other lines", 0, n_oth)
        `CHECK("dstar c clock", 10, n_dc)
        present <= 1'b0;
        watch(100, cfg.refout_line, 1'b0);
        `CHECK("dstar c absent", 0, n_dc)
        present <= 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            cfg = '0;
            cfg.sync_role_setting = clock_routing_pkg::sync_role_setting_e'(m);
            cfg.trig_export_en = 1'b1;
            cfg.trig_out_line = 3'($urandom);
            cfg.dstar_c_en = 1'b1;
            set_ctrl(5);
            apb(1'b1, clock_routing_pkg::ADDR_CMD, clock_routing_pkg::CMD_START);
            watch(20, cfg.trig_out_line, 1'b0);
            `CHECK("start on bus", m, n_bus)
            `CHECK("start on dstar c", m, n_dc)
        end
        $display("export test done");
        peer_oe <= 8'hff;
        star_clock <= 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            cfg = '0;
            cfg.skew_en = k[2];
            cfg.trig_src = clock_routing_pkg::trig_src_e'(k[1:0] | {2{k[3]}});
            cfg.trig_line = 3'($urandom);
            present <= !k[3];
            set_ctrl(20);
            watch(40, 3'h0, 1'b1);
            `CHECK("trigger count", int'(!k[3]), cnt)
            if (k < 4)
                `CHECK("trigger delay", 3, lat)
            else if (k < 8)
            begin
                `CHECK("skew later", 1'b1, lat > 3)
                `CHECK("skew on sync", 1'b1, lat_sync)
            end
        end
        $display("trigger test done");
        test_done();
    end
endmodule : reference_clock_and_trigger_routing_tb
`default_nettype wire
